// ===== verilog/expansion_pkg.sv
// expansion connector sideband control: shared constants and carriers
// assumes a single 125 MHz clock domain with synchronous active-high reset
package expansion_pkg;

   // -----------------------------------------------------------------
   // rom window and bus widths
   // -----------------------------------------------------------------
   localparam int unsigned ROM_ADDR_W      = 16;
   localparam int unsigned ROM_DATA_W      = 8;
   localparam int unsigned IRQ_W           = 8;
   localparam logic [31:0] ROM_REGION_LO   = 32'h0C00_0000; // 192 MB
   localparam logic [31:0] ROM_REGION_HI   = 32'h0E00_0000; // 224 MB

   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS   = 8;
   localparam int unsigned BOARD_CLK_MHZ   = 25;
   localparam int unsigned ROM_ACCESS_NS   = 120;
   localparam int unsigned ROM_ACCESS_CYC  =
      (ROM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned BOARD_RESET_NS  = 1000;
   localparam int unsigned BOARD_RESET_CYC =
      (BOARD_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic RST_GRANT_N  = 1'b1;
   localparam logic RST_REQ_N    = 1'b1;
   localparam logic RST_ROM_N    = 1'b1;

   // -----------------------------------------------------------------
   // carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
      logic [7:0]  wdata;
   } cpu_req_s;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  dout;
      logic        dout_en;
      logic        select_n;
      logic        oe_n;
      logic        we_n;
   } rom_pins_s;

   typedef enum logic [1:0] {
      ROM_IDLE = 2'b00,
      ROM_ACT  = 2'b01,
      ROM_DONE = 2'b11
   } rom_state_e;

   function automatic logic in_rom_region(input logic [31:0] a);
      in_rom_region = (a >= ROM_REGION_LO) && (a < ROM_REGION_HI);
   endfunction

endpackage

// ===== verilog/pin_sync.sv
// three-stage synchroniser for asynchronous pin inputs
// assumes clk_i is the only clock; change accepted when stages 2 and 3 agree
`timescale 1ns/1ps
module pin_sync #(
   parameter int unsigned W = 1,
   parameter logic [W-1:0] INIT = '1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         ce_i,
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] level_o
);
   logic [W-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
   logic [W-1:0] s1_next, s2_next, s3_next, lvl_next;

   always_comb begin
      s1_next  = pin_i;
      s2_next  = s1_reg;
      s3_next  = s2_reg;
      lvl_next = lvl_reg;
      for (int i = 0; i < W; i++) begin
         if (s2_reg[i] == s3_reg[i]) begin
            lvl_next[i] = s3_reg[i];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_reg  <= INIT;
         s2_reg  <= INIT;
         s3_reg  <= INIT;
         lvl_reg <= INIT;
      end else if (ce_i) begin
         s1_reg  <= s1_next;
         s2_reg  <= s2_next;
         s3_reg  <= s3_next;
         lvl_reg <= lvl_next;
      end
   end

   assign level_o = lvl_reg;
endmodule

// ===== verilog/expansion_bus_control.sv
// expansion connector sideband: request/grant, rom bus, detect, reset,
// board clock and interrupt line capture
// assumes one 125 MHz clock; pins arrive asynchronously
`timescale 1ns/1ps
module expansion_bus_control #(
   parameter int unsigned RESET_CYC = expansion_pkg::BOARD_RESET_CYC
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 ce_i,
   // board arbitration
   input  wire logic                 board_bus_request_n_i,
   input  wire logic                 arb_board_grant_i,
   output logic                      board_bus_grant_n_o,
   output logic                      board_request_o,
   // host interface requests
   input  wire logic                 master_need_i,
   input  wire logic                 master_done_i,
   input  wire logic                 slave_need_i,
   input  wire logic                 slave_done_i,
   output logic                      hostif_master_request_n_o,
   output logic                      hostif_slave_request_n_o,
   input  wire logic                 hostif_master_ack_n_i,
   input  wire logic                 hostif_slave_ack_n_i,
   output logic                      master_owned_o,
   output logic                      slave_owned_o,
   // watchdog
   input  wire logic                 watchdog_timeout_n_i,
   output logic                      watchdog_event_o,
   // processor side rom access
   input  wire expansion_pkg::cpu_req_s cpu_req_i,
   output logic                      cpu_done_o,
   output logic [7:0]                cpu_rdata_o,
   // rom pins
   output logic [15:0]               boot_rom_addr_o,
   output logic [7:0]                boot_rom_data_o,
   output logic                      boot_rom_data_oe_o,
   input  wire logic [7:0]           boot_rom_data_i,
   output logic                      boot_rom_select_n_o,
   output logic                      boot_rom_read_enable_n_o,
   output logic                      boot_rom_write_enable_n_o,
   // presence, reset, clock, interrupts
   input  wire logic                 board_present_n_i,
   output logic                      board_attached_o,
   input  wire logic                 board_reset_req_i,
   output logic                      board_reset_n_o,
   output logic                      board_clock_o,
   input  wire logic [7:0]           board_irq_lines_n_i,
   input  wire logic                 irq_vector_mode_select_i,
   output logic                      irq_vector_valid_o,
   output logic [7:0]                irq_vector_o,
   output logic [7:0]                irq_direct_o
);

   // -----------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------
   logic       req1_s, mack_s, sack_s, watchdog_timeout_n_s, pres_s;
   logic [7:0] irq_s;

   pin_sync #(.W(13), .INIT(13'h1FFF)) u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .pin_i   ({board_bus_request_n_i, hostif_master_ack_n_i,
                 hostif_slave_ack_n_i, watchdog_timeout_n_i,
                 board_present_n_i, board_irq_lines_n_i}),
      .level_o ({req1_s, mack_s, sack_s, watchdog_timeout_n_s, pres_s, irq_s})
   );

   // -----------------------------------------------------------------
   // arbitration sideband
   // -----------------------------------------------------------------
   logic gnt_reg, gnt_next, mreq_reg, mreq_next, sreq_reg, sreq_next;
   logic breq_reg, breq_next, mown_reg, mown_next, sown_reg, sown_next;

   always_comb begin
      breq_next = ~req1_s;
      // grant only while the board still requests
      gnt_next  = ~(arb_board_grant_i & ~req1_s);
      mreq_next = mreq_reg;
      if (master_need_i && mreq_reg) begin
         mreq_next = 1'b0;
      end else if (master_done_i && !mreq_reg) begin
         mreq_next = 1'b1;
      end
      sreq_next = sreq_reg;
      if (slave_need_i && sreq_reg) begin
         sreq_next = 1'b0;
      end else if (slave_done_i && !sreq_reg) begin
         sreq_next = 1'b1;
      end
      mown_next = ~mreq_reg & ~mack_s;
      sown_next = ~sreq_reg & ~sack_s;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gnt_reg  <= expansion_pkg::RST_GRANT_N;
         mreq_reg <= expansion_pkg::RST_REQ_N;
         sreq_reg <= expansion_pkg::RST_REQ_N;
         breq_reg <= 1'b0;
         mown_reg <= 1'b0;
         sown_reg <= 1'b0;
      end else if (ce_i) begin
         gnt_reg  <= gnt_next;
         mreq_reg <= mreq_next;
         sreq_reg <= sreq_next;
         breq_reg <= breq_next;
         mown_reg <= mown_next;
         sown_reg <= sown_next;
      end
   end

   // -----------------------------------------------------------------
   // watchdog edge
   // -----------------------------------------------------------------
   logic wd_prev_reg, wd_prev_next, wd_evt_reg, wd_evt_next;

   always_comb begin
      wd_prev_next = watchdog_timeout_n_s;
      wd_evt_next  = wd_prev_reg & ~watchdog_timeout_n_s;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wd_prev_reg <= 1'b1;
         wd_evt_reg  <= 1'b0;
      end else if (ce_i) begin
         wd_prev_reg <= wd_prev_next;
         wd_evt_reg  <= wd_evt_next;
      end
   end

   // -----------------------------------------------------------------
   // rom bus
   // -----------------------------------------------------------------
   localparam int unsigned CW = $clog2(expansion_pkg::ROM_ACCESS_CYC + 1);

   expansion_pkg::rom_state_e st_reg, st_next;
   expansion_pkg::rom_pins_s  rp_reg, rp_next;
   logic [CW-1:0]             cnt_reg, cnt_next;
   logic                      done_reg, done_next;
   logic [7:0]                rd_reg, rd_next;

   always_comb begin
      st_next   = st_reg;
      rp_next   = rp_reg;
      cnt_next  = cnt_reg;
      done_next = 1'b0;
      rd_next   = rd_reg;
      case (st_reg)
         expansion_pkg::ROM_IDLE: begin
            if (cpu_req_i.valid &&
                expansion_pkg::in_rom_region(cpu_req_i.addr)) begin
               rp_next.addr     = cpu_req_i.addr[15:0];
               rp_next.dout     = cpu_req_i.wdata;
               rp_next.dout_en  = cpu_req_i.write;
               rp_next.select_n = 1'b0;
               rp_next.oe_n     = cpu_req_i.write;
               rp_next.we_n     = ~cpu_req_i.write;
               cnt_next = CW'(expansion_pkg::ROM_ACCESS_CYC - 1);
               st_next  = expansion_pkg::ROM_ACT;
            end
         end
         expansion_pkg::ROM_ACT: begin
            if (cnt_reg == '0) begin
               rd_next          = boot_rom_data_i;
               rp_next.select_n = 1'b1;
               rp_next.oe_n     = 1'b1;
               rp_next.we_n     = 1'b1;
               rp_next.dout_en  = 1'b0;
               done_next        = 1'b1;
               st_next          = expansion_pkg::ROM_DONE;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         expansion_pkg::ROM_DONE: st_next = expansion_pkg::ROM_IDLE;
         default: st_next = expansion_pkg::ROM_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg   <= expansion_pkg::ROM_IDLE;
         rp_reg   <= '{addr: 16'h0000, dout: 8'h00, dout_en: 1'b0,
                       select_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
         cnt_reg  <= '0;
         done_reg <= 1'b0;
         rd_reg   <= 8'h00;
      end else if (ce_i) begin
         st_reg   <= st_next;
         rp_reg   <= rp_next;
         cnt_reg  <= cnt_next;
         done_reg <= done_next;
         rd_reg   <= rd_next;
      end
   end

   // -----------------------------------------------------------------
   // presence, board reset, board clock, interrupts
   // -----------------------------------------------------------------
   localparam int unsigned RW = $clog2(RESET_CYC + 1);
   // 125/25 -> toggle every 2.5 cycles is impossible; divide by 5 with
   // a 2/3 duty split, limitation accepted since the edge rate is exact
   localparam int unsigned DIV = 1000 /
      (expansion_pkg::CLK_PERIOD_NS * expansion_pkg::BOARD_CLK_MHZ);

   logic          att_reg, att_next, clk_reg, clk_next;
   logic [2:0]    div_reg, div_next;
   logic [RW-1:0] rc_reg, rc_next;
   logic          rst_n_reg, rst_n_next;
   logic          vv_reg, vv_next;
   logic [7:0]    vec_reg, vec_next, dir_reg, dir_next;

   always_comb begin
      att_next   = ~pres_s;
      div_next   = (div_reg == 3'(DIV - 1)) ? 3'h0 : div_reg + 3'h1;
      clk_next   = (div_next < 3'h2);
      rc_next    = rc_reg;
      if (board_reset_req_i) begin
         rc_next = RW'(RESET_CYC);
      end else if (rc_reg != '0) begin
         rc_next = rc_reg - 1'b1;
      end
      rst_n_next = (rc_next == '0);
      // lines are active low; inversion gives active-high bits
      vv_next    = irq_vector_mode_select_i && (irq_s != 8'hFF);
      vec_next   = irq_vector_mode_select_i ? ~irq_s : 8'h00;
      dir_next   = irq_vector_mode_select_i ? 8'h00 : ~irq_s;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         att_reg   <= 1'b0;
         div_reg   <= 3'h0;
         clk_reg   <= 1'b0;
         rc_reg    <= RW'(RESET_CYC);
         rst_n_reg <= 1'b0;
         vv_reg    <= 1'b0;
         vec_reg   <= 8'h00;
         dir_reg   <= 8'h00;
      end else if (ce_i) begin
         att_reg   <= att_next;
         div_reg   <= div_next;
         clk_reg   <= clk_next;
         rc_reg    <= rc_next;
         rst_n_reg <= rst_n_next;
         vv_reg    <= vv_next;
         vec_reg   <= vec_next;
         dir_reg   <= dir_next;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign board_bus_grant_n_o       = gnt_reg;
   assign board_request_o           = breq_reg;
   assign hostif_master_request_n_o = mreq_reg;
   assign hostif_slave_request_n_o  = sreq_reg;
   assign master_owned_o            = mown_reg;
   assign slave_owned_o             = sown_reg;
   assign watchdog_event_o          = wd_evt_reg;
   assign cpu_done_o                = done_reg;
   assign cpu_rdata_o               = rd_reg;
   assign boot_rom_addr_o           = rp_reg.addr;
   assign boot_rom_data_o           = rp_reg.dout;
   assign boot_rom_data_oe_o        = rp_reg.dout_en;
   assign boot_rom_select_n_o       = rp_reg.select_n;
   assign boot_rom_read_enable_n_o  = rp_reg.oe_n;
   assign boot_rom_write_enable_n_o = rp_reg.we_n;
   assign board_attached_o          = att_reg;
   assign board_reset_n_o           = rst_n_reg;
   assign board_clock_o             = clk_reg;
   assign irq_vector_valid_o        = vv_reg;
   assign irq_vector_o              = vec_reg;
   assign irq_direct_o              = dir_reg;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   sel_region_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_reg == expansion_pkg::ROM_IDLE && ce_i && cpu_req_i.valid &&
       !expansion_pkg::in_rom_region(cpu_req_i.addr))
      |=> boot_rom_select_n_o)
      else $error("rom select outside region");
   oe_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !boot_rom_read_enable_n_o |-> !boot_rom_select_n_o &&
      !boot_rom_data_oe_o)
      else $error("rom read enable outside read");
   we_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !boot_rom_write_enable_n_o |-> boot_rom_read_enable_n_o &&
      boot_rom_data_oe_o)
      else $error("rom write enable during read");
   rom_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(boot_rom_select_n_o) |->
      boot_rom_addr_o == $past(cpu_req_i.addr[15:0]))
      else $error("rom address mismatch");
   grant_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !board_bus_grant_n_o |-> $past(!req1_s))
      else $error("grant without request");
   mreq_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !hostif_master_request_n_o && !master_done_i
      |=> !hostif_master_request_n_o)
      else $error("master request dropped early");
   sreq_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !hostif_slave_request_n_o && !slave_done_i
      |=> !hostif_slave_request_n_o)
      else $error("slave request dropped early");
   watchdog_timeout_n_event_a: assert property (@(posedge clk_i) disable iff (rst_i)
      watchdog_event_o && ce_i |=> !watchdog_event_o)
      else $error("watchdog event longer than one cycle");
   reset_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && board_reset_req_i |=> !board_reset_n_o)
      else $error("board reset not asserted");
   irq_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (irq_vector_o & irq_direct_o) == 8'h00)
      else $error("both interrupt modes active");

   rom_read_c:  cover property (@(posedge clk_i)
      $fell(boot_rom_read_enable_n_o));
   rom_write_c: cover property (@(posedge clk_i)
      $fell(boot_rom_write_enable_n_o));
   grant_c:     cover property (@(posedge clk_i) $fell(board_bus_grant_n_o));
   watchdog_timeout_n_c:      cover property (@(posedge clk_i) watchdog_event_o);
endmodule

// ===== tb/board_rom_model.sv
// add-on board byte store hanging on the rom bus
// assumes rom strobes from the controller are registered on clk_i
`timescale 1ns/1ps
module board_rom_model (
   input  wire logic        clk_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        wdata_oe_i,
   input  wire logic        select_n_i,
   input  wire logic        read_enable_n_i,
   input  wire logic        write_enable_n_i,
   output logic      [7:0]  data_o
);
   logic [7:0] mem [0:65535];
   logic [7:0] last = 8'h00;

   // released bus shows the inverse of the last byte, never a stale copy
   always_comb begin
      if (!select_n_i && !read_enable_n_i) begin
         data_o = mem[addr_i];
      end else begin
         data_o = ~last;
      end
   end

   always @(posedge clk_i) begin
      if (!select_n_i && !read_enable_n_i) begin
         last <= mem[addr_i];
      end
      if (!select_n_i && !write_enable_n_i && wdata_oe_i) begin
         mem[addr_i] <= wdata_i;
      end
   end
endmodule

// ===== tb/expansion_bus_control_test.sv
// self-checking bench for the expansion sideband controller
// assumes 125 MHz clk_i, synchronous active-high reset
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
   err_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module expansion_bus_control_test;
   localparam int unsigned RST_CYC = 4;
   // take edge, then the full strobe time
   localparam int unsigned ROM_DONE_AT = expansion_pkg::ROM_ACCESS_CYC + 1;
   typedef struct packed {
      logic        write;
      logic [31:0] addr;
      logic [7:0]  data;
      logic        taken;
   } row_s;
   // -----------------------------------------------------------------
   // signals
   // -----------------------------------------------------------------
   logic clk_i = 1'b0, rst_i = 1'b1;
   logic req_n = 1'b1, arb_gnt = 1'b0, m_need = 1'b0, m_done = 1'b0;
   logic s_need = 1'b0, s_done = 1'b0, m_ack_n = 1'b1, s_ack_n = 1'b1;
   logic watchdog_timeout_n_n = 1'b1, present_n = 1'b1, brst_req = 1'b0, vmode = 1'b0;
   logic [7:0] irq_n = 8'hFF;
   logic ce = 1'b1;
   expansion_pkg::cpu_req_s cpu_req = '0;
   logic grant_n, board_req, m_req_n, s_req_n, m_own, s_own, watchdog_timeout_n_ev;
   logic cpu_done, rom_doe, rom_sel_n, rom_oe_n, rom_we_n, attached;
   logic brst_n, bclk, vvalid;
   logic [7:0] cpu_rdata, rom_dout, rom_din, vec, dir;
   logic [15:0] rom_addr;
   int err_count = 0, comparisons = 0, cycles = 0, n;
   realtime t;
   // boundaries of the decoded window, both sides of each edge
   row_s rows [6] = '{
      '{1'b1, 32'h0C00_0000, 8'hA5, 1'b1}, '{1'b0, 32'h0C00_0000, 8'hA5, 1'b1},
      '{1'b1, 32'h0DFF_FFFF, 8'h3C, 1'b1}, '{1'b0, 32'h0DFF_FFFF, 8'h3C, 1'b1},
      '{1'b0, 32'h0BFF_FFFF, 8'h00, 1'b0}, '{1'b1, 32'h0E00_0000, 8'h11, 1'b0}};

   expansion_bus_control #(.RESET_CYC(RST_CYC)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
      .board_bus_request_n_i(req_n), .arb_board_grant_i(arb_gnt),
      .board_bus_grant_n_o(grant_n), .board_request_o(board_req),
      .master_need_i(m_need), .master_done_i(m_done),
      .slave_need_i(s_need), .slave_done_i(s_done),
      .hostif_master_request_n_o(m_req_n),
      .hostif_slave_request_n_o(s_req_n),
      .hostif_master_ack_n_i(m_ack_n), .hostif_slave_ack_n_i(s_ack_n),
      .master_owned_o(m_own), .slave_owned_o(s_own),
      .watchdog_timeout_n_i(watchdog_timeout_n_n), .watchdog_event_o(watchdog_timeout_n_ev),
      .cpu_req_i(cpu_req), .cpu_done_o(cpu_done), .cpu_rdata_o(cpu_rdata),
      .boot_rom_addr_o(rom_addr), .boot_rom_data_o(rom_dout),
      .boot_rom_data_oe_o(rom_doe), .boot_rom_data_i(rom_din),
      .boot_rom_select_n_o(rom_sel_n), .boot_rom_read_enable_n_o(rom_oe_n),
      .boot_rom_write_enable_n_o(rom_we_n),
      .board_present_n_i(present_n), .board_attached_o(attached),
      .board_reset_req_i(brst_req), .board_reset_n_o(brst_n),
      .board_clock_o(bclk), .board_irq_lines_n_i(irq_n),
      .irq_vector_mode_select_i(vmode), .irq_vector_valid_o(vvalid),
      .irq_vector_o(vec), .irq_direct_o(dir));

   board_rom_model i_rom (
      .clk_i(clk_i), .addr_i(rom_addr), .wdata_i(rom_dout),
      .wdata_oe_i(rom_doe), .select_n_i(rom_sel_n),
      .read_enable_n_i(rom_oe_n), .write_enable_n_i(rom_we_n),
      .data_o(rom_din));

   // -----------------------------------------------------------------
   // clock, timeout, closing
   // -----------------------------------------------------------------
   initial forever #4 clk_i = ~clk_i;

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // whole run is well under a thousand cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         stop_test();
      end
   end

   task automatic cyc(input int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask

   // -----------------------------------------------------------------
   // transfer tasks
   // -----------------------------------------------------------------
   task automatic rom_op(input row_s r);
      @(posedge clk_i);
      cpu_req <= '{1'b1, r.write, r.addr, r.data};
      n = 0;
      while (n < 30 && cpu_done !== 1'b1) begin
         cyc(1);
         n++;
         if (n == 5) begin
            `CHK("rom select", ~r.taken, rom_sel_n)
            `CHK("rom oe", ~(r.taken & ~r.write), rom_oe_n)
            `CHK("rom we", ~(r.taken & r.write), rom_we_n)
            `CHK("rom drive", r.taken & r.write, rom_doe)
            if (r.taken) `CHK("rom addr", r.addr[15:0], rom_addr)
         end
      end
      `CHK("rom done at", r.taken ? ROM_DONE_AT : 30, n)
      if (r.taken && !r.write) `CHK("rom rdata", r.data, cpu_rdata)
      @(posedge clk_i);
      cpu_req <= '0;
   endtask

   task automatic hostif_case(input bit slave);
      @(posedge clk_i);
      if (slave) s_need <= 1'b1; else m_need <= 1'b1;
      @(posedge clk_i);
      s_need <= 1'b0;
      m_need <= 1'b0;
      #1;
      `CHK("request low", 1'b0, slave ? s_req_n : m_req_n)
      `CHK("other idle", 1'b1, slave ? m_req_n : s_req_n)
      `CHK("owned early", 1'b0, slave ? s_own : m_own)
      @(posedge clk_i);
      if (slave) s_ack_n <= 1'b0; else m_ack_n <= 1'b0;
      cyc(8);
      `CHK("owned", 1'b1, slave ? s_own : m_own)
      `CHK("request held", 1'b0, slave ? s_req_n : m_req_n)
      @(posedge clk_i);
      if (slave) s_done <= 1'b1; else m_done <= 1'b1;
      @(posedge clk_i);
      s_done <= 1'b0;
      m_done <= 1'b0;
      s_ack_n <= 1'b1;
      m_ack_n <= 1'b1;
      #1;
      `CHK("request released", 1'b1, slave ? s_req_n : m_req_n)
      cyc(8);
      `CHK("owned cleared", 1'b0, slave ? s_own : m_own)
   endtask

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (rows[i]) rom_op(rows[i]);
      $display("test rom rows done");
      // second reset in mid-run, with requests pending
      @(posedge clk_i);
      rst_i <= 1'b1;
      m_need <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      m_need <= 1'b0;
      #1;
      `CHK("grant idle", 1'b1, grant_n)
      `CHK("master idle", 1'b1, m_req_n)
      `CHK("slave idle", 1'b1, s_req_n)
      `CHK("select idle", 1'b1, rom_sel_n)
      `CHK("board reset low", 1'b0, brst_n)
      cyc(RST_CYC + 3);
      `CHK("board reset high", 1'b1, brst_n)
      @(posedge bclk);
      t = $realtime;
      @(posedge bclk);
      `CHK("board clk ns", 40, int'($realtime - t))
      // clock enable low must freeze the divider as well
      @(posedge clk_i);
      ce <= 1'b0;
      cyc(1);
      n = bclk;
      repeat (4) begin
         cyc(1);
         `CHK("clock frozen", n, bclk)
      end
      @(posedge clk_i);
      ce <= 1'b1;
      $display("test reset and clock done");
      @(posedge clk_i);
      req_n <= 1'b0;
      arb_gnt <= 1'b1;
      cyc(8);
      `CHK("board grant", 1'b0, grant_n)
      `CHK("board request", 1'b1, board_req)
      @(posedge clk_i);
      req_n <= 1'b1;
      cyc(8);
      `CHK("grant unasked", 1'b1, grant_n)
      arb_gnt <= 1'b0;
      hostif_case(1'b0);
      hostif_case(1'b1);
      $display("test arbitration done");
      @(posedge clk_i);
      watchdog_timeout_n_n <= 1'b0;
      n = 0;
      repeat (12) begin
         cyc(1);
         if (watchdog_timeout_n_ev === 1'b1) n++;
      end
      `CHK("watchdog pulses", 1, n)
      watchdog_timeout_n_n <= 1'b1;
      for (int m = 0; m < 2; m++) begin
         @(posedge clk_i);
         vmode <= m[0];
         irq_n <= 8'h5A;
         present_n <= m[0];
         cyc(8);
         `CHK("irq vector", m ? 8'hA5 : 8'h00, vec)
         `CHK("irq direct", m ? 8'h00 : 8'hA5, dir)
         `CHK("irq valid", m[0], vvalid)
         `CHK("attached", ~m[0], attached)
      end
      irq_n <= 8'hFF;
      brst_req <= 1'b1;
      cyc(4);
      `CHK("board reset req", 1'b0, brst_n)
      brst_req <= 1'b0;
      $display("test sideband done");
      stop_test();
   end
endmodule
